// ==== inc/ptb_map.vh ====
// Register map and constants for the pattern self-test and loopback control block
`ifndef PTB_MAP_VH
`define PTB_MAP_VH
// Register byte offsets
`define PTB_OFS_CTRL     12'h000
`define PTB_OFS_IRQ_STAT 12'h004
`define PTB_OFS_IRQ_EN   12'h008
`define PTB_OFS_IRQ_CLR  12'h00c
`define PTB_OFS_ERRCNT   12'h010
// Control register fields
`define PTB_B_WRAP       14
`define PTB_B_KIND       13
`define PTB_B_GEN_EN     12
`define PTB_B_LOCKED     11
`define PTB_B_LOST       10
`define PTB_B_GEN_ST     9
`define PTB_B_LINE_OUT   6
`define PTB_LB_HI        5
`define PTB_LB_LO        2
// Fixed bits 8:7 read as binary 10, bits 1:0 writable spare
`define PTB_RSV_87       2'h2
`define PTB_CTRL_RW_MASK 16'h7047
// Loopback codes
`define PTB_LB_NORMAL    4'h0
`define PTB_LB_PCS       4'h1
`define PTB_LB_ANALOG    4'h2
`define PTB_LB_REVERSE   4'h4
`define PTB_LB_RESERVED  4'h8
// Interrupt event bits
`define PTB_IRQ_WRAP     0
`define PTB_IRQ_LOST     1
`define PTB_IRQ_DONE     2
`define PTB_IRQ_W        3
// Pattern generator
`define PTB_SEED         15'h7fff
`define PTB_CONST_BYTE   8'h55
`define PTB_LOCK_RUN     4'h8
`define PTB_LOSE_RUN     4'h4
`endif

// ==== hw/ptb_prbs_step.v ====
// PRBS-15 shift step, eight bits per call
`timescale 1ns/100ps
`default_nettype none
module ptb_prbs_step (
  // State in
  input  wire [14:0] state_in,
  // Next state and byte out
  output reg  [14:0] state_out,
  output reg  [7:0]  byte_out
);
  integer i;
  reg [14:0] s;
  reg        fb;
  // Shift eight times, x^15 + x^14 + 1
  always @* begin
    s = state_in;
    byte_out = 8'h00;
    fb = 1'b0;
    for (i = 0; i < 8; i = i + 1) begin
      fb = s[14] ^ s[13];
      byte_out[i] = fb;
      s = {s[13:0], fb};
    end
    state_out = s;
  end
endmodule // ptb_prbs_step
`default_nettype wire

// ==== hw/ptb_ctrl.v ====
// Pattern self-test, error counter and loopback control with APB registers
//
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "ptb_map.vh"
module ptb_ctrl #(
  parameter CNT_W   = 16,
  parameter PKT_LEN = 64
) (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        rst,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // Transmit stream toward the line
  output reg  [7:0]  tx_data,
  output reg         tx_valid,
  output reg         tx_last,
  // Received stream for the checker
  input  wire [7:0]  rx_data,
  input  wire        rx_valid,
  // MAC-interface loopback indication from the data path
  input  wire        mac_lb_active,
  output wire        line_tx_enable,
  // Loopback selection to the data path
  output wire [3:0]  loop_sel,
  output wire        err_wrap_pulse,
  // Interrupt
  output wire        irq
);
  ////////////////////////////////////////////////////////////////////////
  // Control register bits
  reg              err_count_wrap_mode;
  reg              pattern_packet_kind;
  reg              gen_enable;
  reg  [3:0]       lb_sel;
  reg              line_out;
  reg  [1:0]       spare;
  reg              checker_locked;
  reg              checker_lost_lock;
  reg              gen_active;
  reg  [CNT_W-1:0] err_count;
  reg  [`PTB_IRQ_W-1:0] irq_stat;
  reg  [`PTB_IRQ_W-1:0] irq_en;
  reg              wrap_pulse;
  reg              done_pulse;

  wire acc     = psel & penable;
  wire wr      = acc & pwrite;
  wire rd      = acc & ~pwrite;
  wire hit_ctl = (paddr == `PTB_OFS_CTRL);
  wire mapped  = hit_ctl | (paddr == `PTB_OFS_IRQ_STAT) | (paddr == `PTB_OFS_IRQ_EN)
               | (paddr == `PTB_OFS_IRQ_CLR) | (paddr == `PTB_OFS_ERRCNT);

  // Zero wait states, unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;

  // Writable control bits
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      err_count_wrap_mode <= 1'b0;
      pattern_packet_kind <= 1'b0;
      gen_enable          <= 1'b0;
      lb_sel              <= `PTB_LB_NORMAL;
      line_out            <= 1'b0;
      spare               <= 2'h0;
      irq_en              <= {`PTB_IRQ_W{1'b0}};
    end else if (wr) begin
      if (hit_ctl) begin
        err_count_wrap_mode <= pwdata[`PTB_B_WRAP];
        pattern_packet_kind <= pwdata[`PTB_B_KIND];
        gen_enable          <= pwdata[`PTB_B_GEN_EN];
        // Reserved code is refused, selection keeps its old value
        if (pwdata[`PTB_LB_HI:`PTB_LB_LO] != `PTB_LB_RESERVED)
          lb_sel <= pwdata[`PTB_LB_HI:`PTB_LB_LO];
        line_out            <= pwdata[`PTB_B_LINE_OUT];
        spare               <= pwdata[1:0];
      end
      if (paddr == `PTB_OFS_IRQ_EN)
        irq_en <= pwdata[`PTB_IRQ_W-1:0];
    end else if (done_pulse) begin
      gen_enable <= 1'b0;
    end
  end

  assign loop_sel = lb_sel;
  // Line output gated only in MAC-interface loopback, otherwise always passes
  assign line_tx_enable = mac_lb_active ? line_out : 1'b1;

  ////////////////////////////////////////////////////////////////////////
  // Packet generator
  reg  [14:0] gen_lfsr;
  reg  [15:0] gen_idx;
  wire [14:0] gen_lfsr_nx;
  wire [7:0]  gen_byte;

  ptb_prbs_step u_gen_step (
    .state_in  (gen_lfsr),
    .state_out (gen_lfsr_nx),
    .byte_out  (gen_byte)
  );

  wire gen_last = (gen_idx == PKT_LEN[15:0] - 16'h0001);

  // One byte per cycle while active; kind 0 ends after one packet
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      gen_lfsr   <= `PTB_SEED;
      gen_idx    <= 16'h0000;
      gen_active <= 1'b0;
      tx_data    <= 8'h00;
      tx_valid   <= 1'b0;
      tx_last    <= 1'b0;
      done_pulse <= 1'b0;
    end else begin
      done_pulse <= 1'b0;
      tx_valid   <= 1'b0;
      tx_last    <= 1'b0;
      if (!gen_enable || done_pulse) begin
        gen_active <= 1'b0;
        gen_idx    <= 16'h0000;
        gen_lfsr   <= `PTB_SEED;
      end else begin
        gen_active <= 1'b1;
        tx_valid   <= 1'b1;
        tx_last    <= gen_last;
        if (pattern_packet_kind) begin
          tx_data  <= gen_byte;
          gen_lfsr <= gen_lfsr_nx;
        end else begin
          tx_data  <= `PTB_CONST_BYTE;
        end
        if (gen_last) begin
          gen_idx <= 16'h0000;
          if (!pattern_packet_kind)
            done_pulse <= 1'b1;
        end else begin
          gen_idx <= gen_idx + 16'h0001;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pattern checker: self-synchronising on received bytes
  reg  [14:0] chk_lfsr;
  reg  [3:0]  good_run;
  reg  [3:0]  bad_run;
  wire [14:0] chk_lfsr_nx;
  wire [7:0]  chk_byte;

  ptb_prbs_step u_chk_step (
    .state_in  (chk_lfsr),
    .state_out (chk_lfsr_nx),
    .byte_out  (chk_byte)
  );

  // The step leaves its newest byte mirrored in the low state bits, so a
  // received byte is mirrored before it seeds the state; without this the
  // checker would follow a different sequence and never lock
  function [7:0] rev8;
    input [7:0] b;
    integer j;
    begin
      for (j = 0; j < 8; j = j + 1)
        rev8[j] = b[7-j];
    end
  endfunction

  wire chk_run  = pattern_packet_kind & rx_valid;
  wire byte_ok  = (chk_byte == rx_data);
  wire cnt_max  = &err_count;
  wire drop     = checker_locked & !byte_ok & (bad_run == `PTB_LOSE_RUN - 4'h1);
  wire read_ctl = rd & hit_ctl;

  // Lock after a run of good bytes, lose after a run of bad ones
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      chk_lfsr          <= `PTB_SEED;
      good_run          <= 4'h0;
      bad_run           <= 4'h0;
      checker_locked    <= 1'b0;
      checker_lost_lock <= 1'b0;
      err_count         <= {CNT_W{1'b0}};
      wrap_pulse        <= 1'b0;
    end else begin
      wrap_pulse <= 1'b0;
      // Set wins over the read clear; stays while sync is still lost
      if (drop)
        checker_lost_lock <= 1'b1;
      else if (read_ctl && checker_locked)
        checker_lost_lock <= 1'b0;
      if (!pattern_packet_kind) begin
        checker_locked <= 1'b0;
        good_run       <= 4'h0;
        bad_run        <= 4'h0;
      end else if (chk_run) begin
        if (!checker_locked) begin
          // Reload from received bits until the stream is followed
          chk_lfsr <= {chk_lfsr_nx[14:8], rev8(rx_data)};
          good_run <= byte_ok ? good_run + 4'h1 : 4'h0;
          if (byte_ok && good_run == `PTB_LOCK_RUN - 4'h1)
            checker_locked <= 1'b1;
        end else begin
          chk_lfsr <= chk_lfsr_nx;
          bad_run  <= byte_ok ? 4'h0 : bad_run + 4'h1;
          if (drop) begin
            checker_locked <= 1'b0;
            good_run       <= 4'h0;
            bad_run        <= 4'h0;
          end
          if (!byte_ok) begin
            if (!cnt_max)
              err_count <= err_count + {{(CNT_W-1){1'b0}}, 1'b1};
            else if (err_count_wrap_mode) begin
              err_count  <= {CNT_W{1'b0}};
              wrap_pulse <= 1'b1;
            end                                          // held at max
          end
        end
      end
    end
  end

  assign err_wrap_pulse = wrap_pulse;

  ////////////////////////////////////////////////////////////////////////
  // Interrupt status, set wins over clear
  wire [`PTB_IRQ_W-1:0] ev  = {done_pulse, drop, wrap_pulse};
  wire [`PTB_IRQ_W-1:0] clr = (wr && paddr == `PTB_OFS_IRQ_CLR) ?
                              pwdata[`PTB_IRQ_W-1:0] : {`PTB_IRQ_W{1'b0}};

  always @(posedge clk_sys or posedge rst) begin
    if (rst)
      irq_stat <= {`PTB_IRQ_W{1'b0}};
    else
      irq_stat <= (irq_stat & ~clr) | ev;
  end

  assign irq = |(irq_stat & irq_en);

  ////////////////////////////////////////////////////////////////////////
  // Read mux, registered
  wire [15:0] ctrl_rd = {1'b0, err_count_wrap_mode, pattern_packet_kind, gen_enable,
                         checker_locked, checker_lost_lock, gen_active, `PTB_RSV_87,
                         line_out, lb_sel, spare};

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `PTB_OFS_CTRL:     prdata <= {16'h0000, ctrl_rd};
        `PTB_OFS_IRQ_STAT: prdata <= {{(32-`PTB_IRQ_W){1'b0}}, irq_stat};
        `PTB_OFS_IRQ_EN:   prdata <= {{(32-`PTB_IRQ_W){1'b0}}, irq_en};
        `PTB_OFS_ERRCNT:   prdata <= {{(32-CNT_W){1'b0}}, err_count};
        default:           prdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule // ptb_ctrl
`default_nettype wire

// ==== dv/ptb_ctrl_chk.sv ====
// Assertion checker for the pattern self-test control block
`timescale 1ns/100ps
`default_nettype none
module ptb_ctrl_chk #(
  parameter CNT_W   = 16,
  parameter PKT_LEN = 64
) (
  // Clock, reset and APB
  input wire logic        clk_sys, rst, psel, penable, pwrite, pready, pslverr,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  // Streams, loopback and interrupt
  input wire logic [7:0]  tx_data, rx_data,
  input wire logic        tx_valid, tx_last, rx_valid, mac_lb_active, line_tx_enable,
  input wire logic [3:0]  loop_sel,
  input wire logic        err_wrap_pulse, irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [15:0] byte_cnt;
  logic        line_bit;
  ////////////////////////////////////////////////////////////////////////////
  // Byte position in packet and a mirror of the stored line-output bit
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      byte_cnt <= 16'h0;
      line_bit <= 1'b0;
    end else begin
      byte_cnt <= (tx_valid && !tx_last) ? byte_cnt + 16'h1 : 16'h0;
      if (psel && penable && pwrite && paddr == 12'h000) line_bit <= pwdata[6];
    end
  end
  sequence ctrl_wr;
    psel && penable && pwrite && paddr == 12'h000;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  loop_code_a: assert property (ctrl_wr ##0 pwdata[5:2] != 4'h8 |=>
    loop_sel == $past(pwdata[5:2])) else $error("loop code not applied");
  loop_rsv_a: assert property (ctrl_wr ##0 pwdata[5:2] == 4'h8 |=>
    $stable(loop_sel)) else $error("reserved loop code taken");
  line_idle_a: assert property (!mac_lb_active |-> line_tx_enable)
    else $error("line blocked outside mac loopback");
  line_pass_a: assert property (mac_lb_active |-> line_tx_enable == line_bit)
    else $error("line enable differs from stored bit");
  gen_start_a: assert property (ctrl_wr ##0 pwdata[12] |-> ##[1:2] tx_valid)
    else $error("generator did not start");
  gen_stop_a: assert property (ctrl_wr ##0 !pwdata[12] |-> ##[1:3] !tx_valid)
    else $error("generator did not stop");
  pkt_len_a: assert property (tx_last |-> tx_valid && byte_cnt == PKT_LEN - 1)
    else $error("packet length wrong");
  wrap_once_a: assert property (err_wrap_pulse |=> !err_wrap_pulse)
    else $error("wrap pulse too long");
endmodule // ptb_ctrl_chk
`default_nettype wire

// ==== dv/ptb_ctrl_tb.sv ====
// Self-checking bench for the pattern self-test control block
`timescale 1ns/100ps
`default_nettype none
`include "ptb_map.vh"
module ptb_ctrl_tb;
  localparam PKT_LEN = 16;
  logic        clk_sys, rst, psel, penable, pwrite, pready, pslverr, tx_valid, tx_last;
  logic        rx_valid, mac_lb_active, line_tx_enable, err_wrap_pulse, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  tx_data, rx_data, flip;
  logic [3:0]  loop_sel;
  logic [3:0]  codes [5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8};
  int          failures, compares, pulses, n, k;
  ptb_ctrl #(.CNT_W(4), .PKT_LEN(PKT_LEN)) u_ptb_ctrl (.clk_sys(clk_sys), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_last(tx_last), .rx_data(rx_data), .rx_valid(rx_valid),
    .mac_lb_active(mac_lb_active), .line_tx_enable(line_tx_enable),
    .loop_sel(loop_sel), .err_wrap_pulse(err_wrap_pulse), .irq(irq));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // Transmit looped into the checker; flip corrupts bytes on purpose
  always @(posedge clk_sys) begin
    rx_data <= tx_data ^ flip;
    rx_valid <= tx_valid;
    if (err_wrap_pulse === 1'b1) pulses <= pulses + 1;
  end
  ////////////////////////////////////////////////////////////////////////////
  task chk(input [31:0] seen, input [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One APB transfer; ends off-edge so outputs are settled for checks
  task apb(input [11:0] a, input w, input [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge clk_sys);
  endtask
  task errs(input int cnt, input int len);
    repeat (cnt) begin
      @(posedge clk_sys);
      flip <= 8'hff;
      repeat (len) @(posedge clk_sys);
      flip <= 8'h00;
      repeat (6) @(posedge clk_sys);
    end
  endtask
  task wrap_up;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata, rx_data, rx_valid, flip} = '0;
    {mac_lb_active, failures, compares, pulses} = '0;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    apb(`PTB_OFS_CTRL, 0, 0);
    chk(rd, 32'h100);
    apb(12'h020, 1, 32'hffff);
    apb(12'h020, 0, 0);
    chk(rd, 0);
    for (k = 0; k < 5; k++) begin
      apb(`PTB_OFS_CTRL, 1, {26'h0, codes[k], 2'h0});
      chk(loop_sel, (k == 4) ? 4'h4 : codes[k]);
    end
    chk(line_tx_enable, 1);
    @(posedge clk_sys) mac_lb_active <= 1'b1;
    @(negedge clk_sys) chk(line_tx_enable, 0);
    apb(`PTB_OFS_CTRL, 1, 32'h40);
    chk(line_tx_enable, 1);
    @(posedge clk_sys) mac_lb_active <= 1'b0;
    $display("loopback test done");
    apb(`PTB_OFS_IRQ_EN, 1, 32'h4);
    apb(`PTB_OFS_CTRL, 1, 32'h1000);
    n = 0;
    for (k = 0; k < 200 && tx_last !== 1'b1; k++) begin
      @(negedge clk_sys);
      n += (tx_valid === 1'b1);
      if (tx_valid === 1'b1) chk(tx_data, 8'h55);
    end
    chk(n, PKT_LEN);
    repeat (4) @(negedge clk_sys);
    chk(irq, 1);
    apb(`PTB_OFS_CTRL, 0, 0);
    chk(rd[12:9], 4'h0);
    apb(`PTB_OFS_IRQ_CLR, 1, 32'h4);
    chk(irq, 0);
    $display("single packet test done");
    apb(`PTB_OFS_CTRL, 1, 32'h7000);
    repeat (40) @(posedge clk_sys);
    apb(`PTB_OFS_CTRL, 0, 0);
    chk(rd, 32'h7b00);
    errs(17, 1);
    chk(pulses, 1);
    apb(`PTB_OFS_CTRL, 1, 32'h3000);
    errs(20, 1);
    apb(`PTB_OFS_ERRCNT, 0, 0);
    chk(rd, 32'hf);
    errs(1, 6);
    repeat (30) @(posedge clk_sys);
    apb(`PTB_OFS_CTRL, 0, 0);
    chk(rd[11:10], 2'h3);
    apb(`PTB_OFS_CTRL, 0, 0);
    chk(rd[11:10], 2'h2);
    apb(`PTB_OFS_IRQ_STAT, 0, 0);
    chk(rd[1:0], 2'h3);
    apb(`PTB_OFS_CTRL, 1, 32'h2000);
    apb(`PTB_OFS_CTRL, 0, 0);
    chk(rd[9], 0);
    $display("pattern stream test done");
    wrap_up;
  end
  // Watchdog well beyond the expected run length
  initial begin
    #100000;
    failures++;
    wrap_up;
  end
endmodule // ptb_ctrl_tb
bind ptb_ctrl ptb_ctrl_chk #(.CNT_W(CNT_W), .PKT_LEN(PKT_LEN)) u_ptb_ctrl_chk (
  .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pready(pready), .pslverr(pslverr), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .tx_data(tx_data), .rx_data(rx_data), .tx_valid(tx_valid), .tx_last(tx_last),
  .rx_valid(rx_valid), .mac_lb_active(mac_lb_active), .line_tx_enable(line_tx_enable),
  .loop_sel(loop_sel), .err_wrap_pulse(err_wrap_pulse), .irq(irq));
`default_nettype wire
